// ---- rtl/psb_buf.sv ----
`timescale 1ns/1ps
`include "psb_map.svh"
module psb_buf #(
  parameter int W = 48,
  parameter int DEPTH = `PSB_BUF_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  psb_stream_if.snk in_s,
  psb_stream_if.src out_s
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  // Pointer wrap
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == LAST) ? '0 : p + PW'(1);
  endfunction

  assign in_s.ready = (cnt_q != FULL);
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem_q[rd_q];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  // Next pointers and fill level
  always_comb begin
    wr_d = push ? bump(wr_q) : wr_q;
    rd_d = pop ? bump(rd_q) : rd_q;
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop & ~push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Entry storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_s.data;
    end
  end
endmodule

// ---- rtl/psb_port.sv ----
`timescale 1ns/1ps
`include "psb_map.svh"
module psb_port #(
  parameter int AW = `PSB_ADDR_W,
  parameter int DW = `PSB_DATA_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  input wire logic output_enable_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic chip_sel1_n,
  input wire logic chip_sel2,
  input wire logic chip_sel3_n,
  input wire logic burst_advance_n,
  input wire logic write_n,
  input wire logic burst_order,
  input wire logic sleep_request,
  output logic sleep_active,
  output logic write_ready
);
  // Counter width and queue word width
  localparam int CW = `PSB_CNT_W;
  localparam int BW = AW + DW;

  // Storage array, no reset; survives sleep
  logic [DW-1:0] mem [2**AW];

  // Two-flop synchronisers for asynchronous pins
  // Enable and sleep therefore lag their pins by three edges
  logic oe_n_m_q, oe_n_s_q, slp_m_q, slp_s_q, ord_m_q, ord_s_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oe_n_m_q <= 1'b1;
      oe_n_s_q <= 1'b1;
      slp_m_q <= 1'b0;
      slp_s_q <= 1'b0;
      ord_m_q <= 1'b1;
      ord_s_q <= 1'b1;
    end else begin
      oe_n_m_q <= output_enable_n;
      oe_n_s_q <= oe_n_m_q;
      slp_m_q <= sleep_request;
      slp_s_q <= slp_m_q;
      ord_m_q <= burst_order;
      ord_s_q <= ord_m_q;
    end
  end

  // Burst low bits from start value and offset
  function automatic logic [CW-1:0] burst_low(input logic [CW-1:0] start,
                                              input logic [CW-1:0] ofs,
                                              input logic interleave);
    burst_low = interleave ? (start ^ ofs) : CW'(start + ofs);
  endfunction

  psb_pkg::psb_state_type state_q, state_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [CW-1:0] start_q, start_d, ofs_q, ofs_d;
  logic order_q, order_d;
  logic desel_q, desel_d, mask_q, mask_d;
  logic [DW-1:0] dout_q, dout_d;
  logic oe_q, oe_d, sleep_q, sleep_d, wr_rdy_q, wr_rdy_d;

  // Decode results
  logic sel, p_go, c_go, go, strobe, kill;
  logic [AW-1:0] eff_addr, new_addr;
  logic hold_wr;

  // Queue word carries address above data
  psb_stream_if #(.W(BW)) wq_in ();
  psb_stream_if #(.W(BW)) wq_out ();

  // Access decode
  always_comb begin
    sel = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n;
    p_go = ~processor_addr_strobe_n & ~chip_sel1_n;
    c_go = ~controller_addr_strobe_n & ~p_go;
    strobe = p_go | ~controller_addr_strobe_n;
    go = (p_go | c_go) & sel & ~slp_s_q;
    kill = strobe & ~sel;
    eff_addr = {addr_q[AW-1:CW], burst_low(start_q, ofs_q, order_q)};
    new_addr = addr;
    hold_wr = ~wq_in.ready;
  end

  // Next state of the access sequencer
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    start_d = start_q;
    ofs_d = ofs_q;
    order_d = order_q;
    desel_d = desel_q;
    mask_d = 1'b0;
    dout_d = dout_q;
    wq_in.valid = 1'b0;
    wq_in.data = {eff_addr, data_in};
    if (state_q == psb_pkg::PSB_READ) begin
      dout_d = mem[eff_addr];
    end
    // Sleep drops any access in progress
    if (slp_s_q) begin
      state_d = psb_pkg::PSB_IDLE;
      desel_d = 1'b1;
    end else if (go) begin
      // Accepted strobe reloads address and counter
      addr_d = new_addr;
      start_d = new_addr[CW-1:0];
      ofs_d = `PSB_CNT_RST;
      order_d = ord_s_q;
      desel_d = 1'b0;
      if (c_go && !write_n) begin
        state_d = psb_pkg::PSB_WRITE;
        wq_in.valid = 1'b1;
        wq_in.data = {new_addr, data_in};
      end else if (p_go) begin
        state_d = psb_pkg::PSB_READ;
        mask_d = desel_q;
      end else begin
        state_d = psb_pkg::PSB_READ;
        mask_d = desel_q;
      end
    end else if (kill) begin
      // Strobe without full select releases the bus
      state_d = psb_pkg::PSB_IDLE;
      desel_d = 1'b1;
    end else if (state_q != psb_pkg::PSB_IDLE) begin
      // Advance steps first, so a burst write beat lands on the
      // next address instead of overwriting the previous beat
      if (!burst_advance_n) begin
        ofs_d = CW'(ofs_q + `PSB_CNT_STEP);
      end
      if (!write_n && !hold_wr) begin
        state_d = psb_pkg::PSB_WRITE;
        wq_in.valid = 1'b1;
        wq_in.data = {addr_q[AW-1:CW], burst_low(start_q, ofs_d, order_q), data_in};
      end else if (write_n) begin
        state_d = psb_pkg::PSB_READ;
      end
    end
  end

  // Output drive and status
  // Mask, deselect and write state override the enable pin
  always_comb begin
    oe_d = (state_d == psb_pkg::PSB_READ) & ~oe_n_s_q & ~mask_d & ~kill;
    sleep_d = slp_s_q;
    wr_rdy_d = wq_in.ready;
  end

  // State registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= psb_pkg::PSB_IDLE;
      addr_q <= `PSB_ADDR_RST;
      start_q <= `PSB_CNT_RST;
      ofs_q <= `PSB_CNT_RST;
      order_q <= 1'b1;
      desel_q <= 1'b1;
      mask_q <= 1'b0;
      dout_q <= `PSB_DATA_RST;
      oe_q <= 1'b0;
      sleep_q <= 1'b0;
      wr_rdy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      start_q <= start_d;
      ofs_q <= ofs_d;
      order_q <= order_d;
      desel_q <= desel_d;
      mask_q <= mask_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      sleep_q <= sleep_d;
      wr_rdy_q <= wr_rdy_d;
    end
  end

  // Write queue in front of the array
  psb_buf #(.W(BW), .DEPTH(`PSB_BUF_DEPTH)) u_wq (
    .clock(clock),
    .rst_n(rst_n),
    .in_s(wq_in),
    .out_s(wq_out)
  );

  // Array writes pause in sleep; contents kept
  assign wq_out.ready = ~slp_s_q;
  always_ff @(posedge clock) begin
    if (wq_out.valid && wq_out.ready) begin
      mem[wq_out.data[BW-1:DW]] <= wq_out.data[DW-1:0];
    end
  end

  // Top outputs come straight from registers
  assign data_out = dout_q;
  assign data_oe = oe_q;
  assign sleep_active = sleep_q;
  assign write_ready = wr_rdy_q;
endmodule

// ---- shared/psb_map.svh ----
`ifndef PSB_MAP_SVH
`define PSB_MAP_SVH
// Array geometry
`define PSB_ADDR_W 16
`define PSB_DATA_W 32
`define PSB_CNT_W 2
// Buffer depth for queued writes
`define PSB_BUF_DEPTH 2
// Reset values
`define PSB_CNT_RST 2'h0
`define PSB_ADDR_RST 16'h0000
`define PSB_DATA_RST 32'h0000_0000
// Burst counter step
`define PSB_CNT_STEP 2'h1
`endif

// ---- shared/psb_pkg.sv ----
package psb_pkg;
  // Access state, one-hot
  typedef enum logic [2:0] {
    PSB_IDLE  = 3'h1,
    PSB_READ  = 3'h2,
    PSB_WRITE = 3'h4
  } psb_state_type;
endpackage

// ---- shared/psb_stream_if.sv ----
`timescale 1ns/1ps
interface psb_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- testbench/psb_bus_host.sv ----
`timescale 1ns/1ps
module psb_bus_host (
  input wire logic clock,
  input wire logic [31:0] data_out,
  input wire logic data_oe,
  input wire logic host_oe,
  input wire logic [31:0] host_data,
  output logic [31:0] data_in
);
  logic [31:0] last_q = 32'h0;
  // Wire level; a released bus toggles every cycle
  always_comb begin
    if (data_oe)
      data_in = data_out;
    else if (host_oe)
      data_in = host_data;
    else
      data_in = ~last_q;
  end
  // Last wire level
  always @(posedge clock) last_q <= data_in;
endmodule

// ---- testbench/psb_port_asserts.sv ----
`timescale 1ns/1ps
module psb_port_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic output_enable_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic chip_sel1_n,
  input wire logic chip_sel2,
  input wire logic chip_sel3_n,
  input wire logic write_n,
  input wire logic sleep_request,
  input wire logic data_oe,
  input wire logic sleep_active,
  input wire logic write_ready
);
  logic sel;
  // All three chip selects active
  assign sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_oe_off; output_enable_n [*4] |=> !data_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven with enable high");
  property p_oe_rise; $rose(data_oe) |-> !$past(output_enable_n, 3); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("bus enabled without enable");
  property p_desel_c; !controller_addr_strobe_n && !sel |=> !data_oe; endproperty
  a_desel_c: assert property (p_desel_c) else $error("bus kept after deselect");
  property p_desel_p; !processor_addr_strobe_n && !chip_sel1_n && !sel |=> !data_oe; endproperty
  a_desel_p: assert property (p_desel_p) else $error("bus kept after deselect");
  property p_first_mask;
    (!controller_addr_strobe_n && !sel) ##1 (!processor_addr_strobe_n && sel && !sleep_active)
    |=> !data_oe;
  endproperty
  a_first_mask: assert property (p_first_mask) else $error("first read cycle driven");
  property p_write_tri;
    !controller_addr_strobe_n && processor_addr_strobe_n && sel && !write_n && write_ready
    && !sleep_request && !sleep_active |=> !data_oe;
  endproperty
  a_write_tri: assert property (p_write_tri) else $error("bus driven in write");
  property p_sleep_on; sleep_request [*4] |=> sleep_active; endproperty
  a_sleep_on: assert property (p_sleep_on) else $error("sleep not entered");
  property p_sleep_off; !sleep_request [*4] |=> !sleep_active; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep not left");
endmodule

// ---- testbench/tb_pipelined_burst_sram_port.sv ----
`timescale 1ns/1ps
module tb_pipelined_burst_sram_port;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] a;
  logic [31:0] data_in, data_out;
  logic [31:0] host_data = 32'h0;
  logic host_oe = 1'b0;
  logic data_oe, sleep_active, write_ready;
  logic output_enable_n = 1'b1, processor_addr_strobe_n = 1'b1, controller_addr_strobe_n = 1'b1;
  logic chip_sel1_n = 1'b1, chip_sel2 = 1'b0, chip_sel3_n = 1'b1, burst_advance_n = 1'b1;
  logic write_n = 1'b1, burst_order = 1'b1, sleep_request = 1'b0;
  logic [31:0] mem [logic [15:0]];
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  psb_port DUT (.clock, .rst_n, .addr, .data_in, .data_out, .data_oe, .output_enable_n,
    .processor_addr_strobe_n, .controller_addr_strobe_n, .chip_sel1_n, .chip_sel2,
    .chip_sel3_n, .burst_advance_n, .write_n, .burst_order, .sleep_request, .sleep_active,
    .write_ready);
  psb_bus_host host (.clock, .data_out, .data_oe, .host_oe, .host_data, .data_in);
  // Clock and hang guard
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1500) begin
      failures++;
      final_report;
    end
  end
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Burst address from start and step
  function automatic logic [15:0] ba(input logic [15:0] s, input int k);
    logic [1:0] o;
    o = k[1:0];
    return {s[15:2], burst_order ? s[1:0] ^ o : s[1:0] + o};
  endfunction
  // Deselecting strobes; processor strobe too while enable is high
  task automatic idle(input logic oe, input int n);
    repeat (n) begin
      @(negedge clock);
      output_enable_n = oe;
      {processor_addr_strobe_n, controller_addr_strobe_n, chip_sel1_n, chip_sel2, chip_sel3_n}
        = {~oe, 4'h0};
      {write_n, burst_advance_n, host_oe} = 3'h6;
    end
  endtask
  // Controller-started write burst; beat 2 has an ignored processor strobe
  task automatic wr(input logic [15:0] s);
    for (int k = 0; k < 4; k++) begin
      @(negedge clock);
      host_data = $urandom;
      {host_oe, write_n, burst_advance_n} = {2'h2, k == 0};
      addr = (k == 2) ? ~s : s;
      {processor_addr_strobe_n, controller_addr_strobe_n, chip_sel1_n, chip_sel2, chip_sel3_n}
        = (k == 0) ? 5'h12 : (k == 2) ? 5'h0e : 5'h1a;
      if (write_ready) mem[ba(s, k)] = host_data;
    end
  endtask
  // Processor-started read burst, optionally with both strobes and write low
  task automatic rd(input logic [15:0] s, input logic both);
    @(negedge clock);
    addr = s;
    {processor_addr_strobe_n, controller_addr_strobe_n, chip_sel1_n, chip_sel2, chip_sel3_n}
      = {1'b0, ~both, 3'h2};
    {write_n, burst_advance_n} = {~both, 1'b1};
    for (int j = 0; j < 5; j++) begin
      @(negedge clock);
      {processor_addr_strobe_n, controller_addr_strobe_n, write_n, burst_advance_n} = 4'he;
      if (j > 0) chk("data_out", mem[ba(s, j - 1)], data_out);
      chk("data_oe", 32'(j > 0), 32'(data_oe));
    end
  endtask
  initial begin
    void'($urandom(80020));
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    for (int m = 0; m < 2; m++) begin
      burst_order = m[0];
      idle(1'b1, 6);
      for (int i = 0; i < 3; i++) begin
        a = 16'($urandom);
        idle(1'b1, 4);
        wr(a);
        idle(1'b0, 4);
        rd(a, 1'b0);
        idle(1'b0, 4);
        rd(a, 1'b1);
      end
    end
    sleep_request = 1'b1;
    idle(1'b0, 8);
    chk("sleep_active", 32'h1, 32'(sleep_active));
    sleep_request = 1'b0;
    idle(1'b0, 6);
    chk("sleep_active", 32'h0, 32'(sleep_active));
    chk("write_ready", 32'h1, 32'(write_ready));
    rd(a, 1'b0);
    final_report;
  end
endmodule
bind psb_port psb_port_asserts u_chk (.clock, .rst_n, .output_enable_n,
  .processor_addr_strobe_n, .controller_addr_strobe_n, .chip_sel1_n, .chip_sel2,
  .chip_sel3_n, .write_n, .sleep_request, .data_oe, .sleep_active, .write_ready);
